/* design/sadm_defines.vh */
// constants for the sdram address and mask decode block
`ifndef SADM_DEFINES_VH
`define SADM_DEFINES_VH
`define SADM_CFG_X4       2'h0
`define SADM_CFG_X8       2'h1
`define SADM_CFG_X16      2'h2
`define SADM_CMD_LMR      3'h0
`define SADM_CMD_REF      3'h1
`define SADM_CMD_PRE      3'h2
`define SADM_CMD_ACT      3'h3
`define SADM_CMD_WR       3'h4
`define SADM_CMD_RD       3'h5
`define SADM_CMD_BST      3'h6
`define SADM_CMD_NOP      3'h7
`define SADM_PRE_BIT      10
`define SADM_RD_MASK_LAT  2
`define SADM_MODE_RST     12'h000
`endif

/* design/sadm_decode.v */
// address, bank and data mask decode of a four-bank sdram pin interface
`timescale 1ns/100ps
`include "sadm_defines.vh"
//
// Contract
// - write data of a lane whose mask is sampled high is discarded and the array keeps its old value.
// - a mask sampled high during a read turns that lane's outputs off two clocks after the sampling edge.
// - in x16 the low byte mask governs data bits 0-7 and the high byte mask bits 8-15.
// - in x4 and x8 the high byte mask is the only mask and the low byte mask is ignored.
// - the two bank select bits choose the bank for activate, read, write and precharge.
// - an activate captures all twelve address inputs as the row of the selected bank.
// - read and write take the start column from bits 0-9 (x4), 0-8 (x8) or 0-7 (x16).
// - address bit 10 on read or write requests auto precharge of the bank after the burst.
// - address bit 10 on precharge high closes all banks, low only the selected bank.
// - load mode register takes the op-code from the address inputs.
// - the data bus is sixteen, eight or four bits wide by configuration, unused pins stay off.
// - all inputs are sampled only on the rising clock edge.
// - with chip select high no new command is taken but bursts and masking continue.
// - the command is decoded from row, column and write strobes with chip select on one edge.
module sadm_decode (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // configuration
  input  wire [1:0]  WIDTH_CFG,
  // command
  input  wire        CHIP_SELECT_N,
  input  wire        ROW_STROBE_N,
  input  wire        COL_STROBE_N,
  input  wire        WRITE_STROBE_N,
  input  wire        BANK_SELECT_BIT0,
  input  wire        BANK_SELECT_BIT1,
  input  wire [11:0] ADDRESS_INPUTS,
  // masks
  input  wire        LOW_BYTE_MASK,
  input  wire        HIGH_BYTE_MASK,
  // burst control from the core
  input  wire        BURST_ACTIVE,
  input  wire        BURST_IS_WRITE,
  // data pins
  input  wire [15:0] DATA_PINS_IN,
  input  wire [15:0] RD_DATA,
  output reg  [15:0] DATA_PINS_OUT,
  output reg  [15:0] DATA_PINS_OE_N,
  // decoded command
  output reg  [2:0]  CMD_OUT,
  output reg  [1:0]  BANK_OUT,
  output reg  [3:0]  ROW_OPEN,
  output reg  [47:0] ROW_ADDR,
  output reg  [9:0]  COL_ADDR,
  output reg         AUTO_PRE,
  output reg  [3:0]  PRE_BANKS,
  output reg  [11:0] MODE_REG,
  // masked write toward the array
  output reg         WR_VALID,
  input  wire        WR_READY,
  output reg  [15:0] WR_DATA,
  output reg  [15:0] WR_KEEP
);

  reg  [2:0]  cmd;
  reg  [1:0]  bank;
  reg  [1:0]  lane_mask;
  reg  [15:0] width_bits;
  reg  [15:0] bit_mask;
  reg  [1:0]  rmask_d1_ff;
  reg  [1:0]  rmask_d2_ff;
  reg  [15:0] buf_data_ff [0:1];
  reg  [15:0] buf_keep_ff [0:1];
  reg  [1:0]  buf_cnt_ff;
  reg         buf_rd_ff;
  reg         buf_wr_ff;
  wire        push;
  wire        pop;
  wire        buf_ready;
  reg  [15:0] rd_off;

  // expand a two-lane byte mask into sixteen bit lanes
  function [15:0] lanes;
    input [1:0] m;
    begin
      lanes = {{8{m[1]}}, {8{m[0]}}};
    end
  endfunction

  // start column for the configured width, upper bits zero
  function [9:0] col_pick;
    input [1:0]  cfg;
    input [11:0] addr;
    begin
      case (cfg)
        `SADM_CFG_X4: col_pick = addr[9:0];
        `SADM_CFG_X8: col_pick = {1'b0, addr[8:0]};
        default:      col_pick = {2'h0, addr[7:0]};
      endcase
    end
  endfunction

  // command and mask decode
  always @* begin
    case ({CHIP_SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N})
      4'h0:    cmd = `SADM_CMD_LMR;
      4'h1:    cmd = `SADM_CMD_REF;
      4'h2:    cmd = `SADM_CMD_PRE;
      4'h3:    cmd = `SADM_CMD_ACT;
      4'h4:    cmd = `SADM_CMD_WR;
      4'h5:    cmd = `SADM_CMD_RD;
      4'h6:    cmd = `SADM_CMD_BST;
      default: cmd = `SADM_CMD_NOP;
    endcase
    bank = {BANK_SELECT_BIT1, BANK_SELECT_BIT0};
    if (WIDTH_CFG == `SADM_CFG_X16) begin
      lane_mask = {HIGH_BYTE_MASK, LOW_BYTE_MASK};
      width_bits = 16'hFFFF;
    end else begin
      lane_mask = {HIGH_BYTE_MASK, HIGH_BYTE_MASK};
      width_bits = (WIDTH_CFG == `SADM_CFG_X8) ? 16'h00FF : 16'h000F;
    end
    bit_mask = lanes(lane_mask);
    rd_off = lanes(rmask_d2_ff);
  end

  // two-entry write buffer
  assign buf_ready = (buf_cnt_ff != 2'h2);
  assign push = BURST_ACTIVE && BURST_IS_WRITE && buf_ready;
  assign pop = WR_VALID && WR_READY;

  // command capture, bank and row tracking
  always @(posedge CLK) begin
    if (RST) begin
      CMD_OUT <= `SADM_CMD_NOP;
      BANK_OUT <= 2'h0;
      ROW_OPEN <= 4'h0;
      ROW_ADDR <= 48'h000000000000;
      COL_ADDR <= 10'h000;
      AUTO_PRE <= 1'b0;
      PRE_BANKS <= 4'h0;
      MODE_REG <= `SADM_MODE_RST;
    end else begin
      CMD_OUT <= cmd;
      PRE_BANKS <= 4'h0;
      AUTO_PRE <= 1'b0;
      case (cmd)
        `SADM_CMD_ACT: begin
          BANK_OUT <= bank;
          ROW_OPEN[bank] <= 1'b1;
          ROW_ADDR[bank*12 +: 12] <= ADDRESS_INPUTS;
        end
        `SADM_CMD_RD, `SADM_CMD_WR: begin
          BANK_OUT <= bank;
          COL_ADDR <= col_pick(WIDTH_CFG, ADDRESS_INPUTS);
          AUTO_PRE <= ADDRESS_INPUTS[`SADM_PRE_BIT];
        end
        `SADM_CMD_PRE: begin
          BANK_OUT <= bank;
          if (ADDRESS_INPUTS[`SADM_PRE_BIT]) begin
            PRE_BANKS <= 4'hF;
            ROW_OPEN <= 4'h0;
          end else begin
            PRE_BANKS[bank] <= 1'b1;
            ROW_OPEN[bank] <= 1'b0;
          end
        end
        `SADM_CMD_LMR: begin
          MODE_REG <= ADDRESS_INPUTS;
        end
        default: begin
          BANK_OUT <= BANK_OUT;
        end
      endcase
    end
  end

  // read mask pipeline and read data pins, kept running while deselected
  always @(posedge CLK) begin
    if (RST) begin
      rmask_d1_ff <= 2'h0;
      rmask_d2_ff <= 2'h0;
      DATA_PINS_OUT <= 16'h0000;
      DATA_PINS_OE_N <= 16'hFFFF;
    end else begin
      rmask_d1_ff <= lane_mask;
      rmask_d2_ff <= rmask_d1_ff;
      DATA_PINS_OUT <= RD_DATA & width_bits;
      DATA_PINS_OE_N <= ~((BURST_ACTIVE && !BURST_IS_WRITE) ? (width_bits & ~rd_off) : 16'h0000);
    end
  end

  // buffer storage; the count guards every read, so no reset is needed
  always @(posedge CLK) begin
    if (push) begin
      buf_data_ff[buf_wr_ff] <= DATA_PINS_IN & width_bits;
      buf_keep_ff[buf_wr_ff] <= bit_mask | ~width_bits;
    end
  end

  // buffer pointers, count and the registered write toward the array
  always @(posedge CLK) begin
    if (RST) begin
      buf_cnt_ff <= 2'h0;
      buf_rd_ff <= 1'b0;
      buf_wr_ff <= 1'b0;
      WR_VALID <= 1'b0;
      WR_DATA <= 16'h0000;
      WR_KEEP <= 16'h0000;
    end else begin
      if (push) begin
        buf_wr_ff <= ~buf_wr_ff;
      end
      if (pop) begin
        buf_rd_ff <= ~buf_rd_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
      if (!WR_VALID || pop) begin
        if (buf_cnt_ff - {1'b0, pop} != 2'h0) begin
          WR_VALID <= 1'b1;
          WR_DATA <= buf_data_ff[buf_rd_ff ^ pop];
          WR_KEEP <= buf_keep_ff[buf_rd_ff ^ pop];
        end else begin
          WR_VALID <= 1'b0;
        end
      end
    end
  end

endmodule // sadm_decode

/* sim/sadm_array_model.sv */
// array side model applying masked writes, with a stall input
`timescale 1ns/100ps
module sadm_array_model (
  // clock, reset and stall control
  input  wire        clk, rst, stall,
  // masked write from the block
  input  wire        wr_valid,
  input  wire [15:0] wr_data, wr_keep,
  output wire        wr_ready,
  // array word
  output reg  [15:0] mem
);
  assign wr_ready = !stall;
  always @(posedge clk)
    if (rst) mem <= 16'hAAAA;
    else if (wr_valid && wr_ready) mem <= (mem & wr_keep) | (wr_data & ~wr_keep);
endmodule // sadm_array_model

/* sim/sadm_decode_checker.sv */
// port assertions for the decode block
`timescale 1ns/100ps
`include "sadm_defines.vh"
module sadm_chk (
  input wire        CLK, RST, CHIP_SELECT_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N,
  input wire        BANK_SELECT_BIT0, BANK_SELECT_BIT1, HIGH_BYTE_MASK, AUTO_PRE,
  input wire [1:0]  WIDTH_CFG, BANK_OUT,
  input wire [2:0]  CMD_OUT,
  input wire [3:0]  ROW_OPEN, PRE_BANKS,
  input wire [9:0]  COL_ADDR,
  input wire [11:0] ADDRESS_INPUTS, MODE_REG,
  input wire [15:0] DATA_PINS_OE_N,
  input wire [47:0] ROW_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire [2:0]  c = CHIP_SELECT_N ? `SADM_CMD_NOP : {ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N};
  wire [1:0]  b = {BANK_SELECT_BIT1, BANK_SELECT_BIT0};
  wire [11:0] a = ADDRESS_INPUTS;
  sequence s_pre; c == `SADM_CMD_PRE; endsequence
  sequence s_rw; c[2:1] == 2'h2; endsequence
  a_cmd_decode: assert property (##1 CMD_OUT == $past(c)) else $error("bad command");
  a_act_capture: assert property (c == `SADM_CMD_ACT |=> BANK_OUT == $past(b) && ROW_ADDR[12*BANK_OUT +: 12] == $past(a))
    else $error("bad row");
  a_pre_all: assert property (s_pre ##0 a[10] |=> PRE_BANKS == 4'hF && ROW_OPEN == 4'h0) else $error("bad pre all");
  a_pre_one: assert property (s_pre ##0 !a[10] |=> PRE_BANKS == 4'h1 << $past(b)) else $error("bad pre");
  a_auto_pre: assert property (s_rw |=> AUTO_PRE == $past(a[10])) else $error("bad auto pre");
  a_col_x16: assert property (s_rw ##0 WIDTH_CFG == `SADM_CFG_X16 |=> COL_ADDR == {2'h0, $past(a[7:0])})
    else $error("bad column");
  a_mode_load: assert property (c == `SADM_CMD_LMR |=> MODE_REG == $past(a)) else $error("bad mode");
  a_rd_mask: assert property (HIGH_BYTE_MASK && WIDTH_CFG == `SADM_CFG_X16 |-> ##3 &DATA_PINS_OE_N[15:8])
    else $error("bad read mask");
endmodule // sadm_chk
bind sadm_decode sadm_chk u_chk (.CLK(CLK), .RST(RST), .CHIP_SELECT_N(CHIP_SELECT_N), .ROW_STROBE_N(ROW_STROBE_N),
  .COL_STROBE_N(COL_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .BANK_SELECT_BIT0(BANK_SELECT_BIT0),
  .BANK_SELECT_BIT1(BANK_SELECT_BIT1), .HIGH_BYTE_MASK(HIGH_BYTE_MASK), .AUTO_PRE(AUTO_PRE), .WIDTH_CFG(WIDTH_CFG),
  .BANK_OUT(BANK_OUT), .CMD_OUT(CMD_OUT), .ROW_OPEN(ROW_OPEN), .PRE_BANKS(PRE_BANKS), .COL_ADDR(COL_ADDR),
  .ADDRESS_INPUTS(ADDRESS_INPUTS), .MODE_REG(MODE_REG), .DATA_PINS_OE_N(DATA_PINS_OE_N), .ROW_ADDR(ROW_ADDR));

/* sim/tb_top.sv */
// bench for the decode block
`timescale 1ns/100ps
`include "sadm_defines.vh"
module tb_top;
  reg         CLK = 0, RST = 1, n = 1, lm = 0, hm = 0, ba = 0, bw = 0, st = 0;
  reg  [1:0]  w = 2, bk = 0;
  reg  [2:0]  c = 7;
  reg  [11:0] a = 0;
  reg  [15:0] d = 0;
  wire [47:0] row;
  wire [15:0] oe, wd, wk, mem, dout;
  wire [11:0] mode;
  wire [9:0]  col;
  wire [3:0]  ro, pre;
  wire        ap, wv, rdy;
  integer     err_total = 0, n_compared = 0, i;
  sadm_decode dut (.CLK(CLK), .RST(RST), .WIDTH_CFG(w), .CHIP_SELECT_N(n), .ROW_STROBE_N(c[2]),
    .COL_STROBE_N(c[1]), .WRITE_STROBE_N(c[0]), .BANK_SELECT_BIT0(bk[0]), .BANK_SELECT_BIT1(bk[1]),
    .ADDRESS_INPUTS(a), .LOW_BYTE_MASK(lm), .HIGH_BYTE_MASK(hm), .BURST_ACTIVE(ba), .BURST_IS_WRITE(bw),
    .DATA_PINS_IN(d), .RD_DATA(d), .DATA_PINS_OUT(dout), .DATA_PINS_OE_N(oe), .CMD_OUT(), .BANK_OUT(),
    .ROW_OPEN(ro), .ROW_ADDR(row), .COL_ADDR(col), .AUTO_PRE(ap), .PRE_BANKS(pre), .MODE_REG(mode),
    .WR_VALID(wv), .WR_READY(rdy), .WR_DATA(wd), .WR_KEEP(wk));
  sadm_array_model pm (.clk(CLK), .rst(RST), .stall(st), .wr_valid(wv), .wr_data(wd), .wr_keep(wk),
    .wr_ready(rdy), .mem(mem));
  task chk(input [47:0] g, x); begin
    n_compared = n_compared + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("mismatch %0t got %h want %h", $time, g, x);
    end
  end endtask
  task cmd(input [2:0] k, input [1:0] b, input [11:0] ad); begin
    @(posedge CLK) begin n <= 0; c <= k; bk <= b; a <= ad; end
    @(posedge CLK) n <= 1;
    #1;
  end endtask
  task close_out; begin
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end endtask
  initial forever #2 CLK = ~CLK;
  initial begin
    #8000;
    err_total = err_total + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 0;
    cmd(`SADM_CMD_LMR, 0, 12'h5A3); chk(mode, 12'h5A3);
    @(posedge CLK) a <= 12'h0FF;
    @(posedge CLK);
    #1 chk(mode, 12'h5A3);
    for (i = 0; i < 4; i = i + 1) begin
      cmd(`SADM_CMD_ACT, i[1:0], {10'h280, i[1:0]});
      chk(row[12*i +: 12], {10'h280, i[1:0]});
    end
    cmd(`SADM_CMD_PRE, 1, 12'h000); chk(ro, 4'hD);
    cmd(`SADM_CMD_PRE, 0, 12'h400); chk(pre, 4'hF);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge CLK) w <= i[1:0];
      cmd(`SADM_CMD_RD, 3, 12'h7FF); chk(col, 10'h3FF >> i);
      chk(ap, 1);
    end
    @(posedge CLK) begin w <= 2; st <= 1; ba <= 1; bw <= 1; d <= 16'h1234; hm <= 1; end
    @(posedge CLK) begin w <= 1; d <= 16'h5678; hm <= 0; lm <= 1; end
    @(posedge CLK) begin ba <= 0; lm <= 0; end
    #1 chk(dout, 16'h0078);
    repeat (4) @(posedge CLK);
    st <= 0;
    repeat (4) @(posedge CLK);
    #1 chk(mem, 16'hAA78);
    @(posedge CLK) begin w <= 2; ba <= 1; bw <= 0; hm <= 1; end
    @(posedge CLK) hm <= 0;
    @(posedge CLK);
    #1 chk(oe, 16'h0000);
    @(posedge CLK);
    #1 chk(oe, 16'hFF00);
    chk(dout, 16'h5678);
    repeat (2) @(posedge CLK);
    close_out;
  end
endmodule // tb_top
